// >>> hdl/pin_edge_change_interrupt.sv
// Pin edge-change interrupt block for one 8-pin port: registers, flags, interrupt, wake
// Assumes a plain register port on mclk_i, pins asynchronous, reset synchronous
`timescale 1ns/1ps
`include "pin_change_cfg.svh"

module pin_edge_change_interrupt (
	input  wire logic                      mclk_i,
	input  wire logic                      rst_i,
	input  wire pin_change_pkg::pin_vec_t  porta_pin_i,
	input  wire pin_change_pkg::addr_t     addr_i,
	input  wire pin_change_pkg::data_t     wr_data_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	output      pin_change_pkg::data_t     rd_data_o,
	output      logic                      change_summary_flag_o,
	output      logic                      change_irq_o,
	output      logic                      wake_o,
	output      logic                      irq_o
);
	pin_change_pkg::pin_vec_t level_w;
	pin_change_pkg::pin_vec_t edge_w;

	pin_change_pkg::pin_vec_t rise_en_reg;
	pin_change_pkg::pin_vec_t rise_en_next;
	pin_change_pkg::pin_vec_t fall_en_reg;
	pin_change_pkg::pin_vec_t fall_en_next;
	pin_change_pkg::pin_vec_t flag_reg;
	pin_change_pkg::pin_vec_t flag_next;
	logic [1:0]               ctrl_reg;
	logic [1:0]               ctrl_next;
	pin_change_pkg::pin_vec_t irq_status_reg;
	pin_change_pkg::pin_vec_t irq_status_next;
	pin_change_pkg::pin_vec_t irq_enable_reg;
	pin_change_pkg::pin_vec_t irq_enable_next;
	pin_change_pkg::data_t    rd_data_reg;
	pin_change_pkg::data_t    rd_data_next;
	logic                     summary_reg;
	logic                     summary_next;
	logic                     change_irq_reg;
	logic                     change_irq_next;
	logic                     wake_reg;
	logic                     wake_next;
	logic                     irq_reg;
	logic                     irq_next;

	logic                     master_en_w;
	logic                     disable_w;
	logic                     wr_rise_w;
	logic                     wr_fall_w;
	logic                     wr_flag_w;
	logic                     wr_ctrl_w;
	logic                     wr_clear_w;
	logic                     wr_ien_w;
	pin_change_pkg::data_t    rd_mux_w;

	function automatic logic hit(input pin_change_pkg::addr_t a, input pin_change_pkg::addr_t ofs);
		hit = (a == ofs);
	endfunction

	pin_sync u_sync (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.pin_i   (porta_pin_i),
		.level_o (level_w)
	);

	edge_detect u_edge (
		.mclk_i    (mclk_i),
		.rst_i     (rst_i),
		.level_i   (level_w),
		.rise_en_i (rise_en_reg),
		.fall_en_i (fall_en_reg),
		.disable_i (disable_w),
		.edge_o    (edge_w)
	);

	assign master_en_w = ctrl_reg[`CTRL_MASTER_EN_BIT];
	assign disable_w   = ctrl_reg[`CTRL_DISABLE_BIT];

	assign wr_rise_w  = wr_i & hit(addr_i, `RISE_EN_OFS);
	assign wr_fall_w  = wr_i & hit(addr_i, `FALL_EN_OFS);
	assign wr_flag_w  = wr_i & hit(addr_i, `EDGE_FLAG_OFS);
	assign wr_ctrl_w  = wr_i & hit(addr_i, `CONTROL_OFS);
	assign wr_clear_w = wr_i & hit(addr_i, `IRQ_CLEAR_OFS);
	assign wr_ien_w   = wr_i & hit(addr_i, `IRQ_ENABLE_OFS);

	assign rise_en_next    = wr_rise_w ? wr_data_i : rise_en_reg;
	assign fall_en_next    = wr_fall_w ? wr_data_i : fall_en_reg;
	assign ctrl_next       = wr_ctrl_w ? wr_data_i[1:0] : ctrl_reg;
	assign irq_enable_next = wr_ien_w ? wr_data_i : irq_enable_reg;

	// Edge set wins over a clearing write in the same cycle
	assign flag_next = (wr_flag_w ? wr_data_i : flag_reg) | edge_w;
	assign irq_status_next = (irq_status_reg & ~(wr_clear_w ? wr_data_i : 8'h00)) | edge_w;

	assign summary_next    = |flag_next;
	assign change_irq_next = summary_next & master_en_w;
	assign wake_next       = (|edge_w) & master_en_w;
	assign irq_next        = |(irq_status_next & irq_enable_next);

	assign rd_mux_w =
		hit(addr_i, `RISE_EN_OFS)    ? rise_en_reg :
		hit(addr_i, `FALL_EN_OFS)    ? fall_en_reg :
		hit(addr_i, `EDGE_FLAG_OFS)  ? flag_reg :
		hit(addr_i, `CONTROL_OFS)    ? {6'h00, ctrl_reg} :
		hit(addr_i, `SUMMARY_OFS)    ? {7'h00, summary_reg} :
		hit(addr_i, `IRQ_STATUS_OFS) ? irq_status_reg :
		hit(addr_i, `IRQ_ENABLE_OFS) ? irq_enable_reg :
		8'h00;
	assign rd_data_next = rd_i ? rd_mux_w : 8'h00;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rise_en_reg <= `PIN_VEC_RESET;
			fall_en_reg <= `PIN_VEC_RESET;
			flag_reg    <= `PIN_VEC_RESET;
			ctrl_reg    <= `CTRL_RESET;
		end else begin
			rise_en_reg <= rise_en_next;
			fall_en_reg <= fall_en_next;
			flag_reg    <= flag_next;
			ctrl_reg    <= ctrl_next;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			irq_status_reg <= `PIN_VEC_RESET;
			irq_enable_reg <= `PIN_VEC_RESET;
			irq_reg        <= 1'b0;
		end else begin
			irq_status_reg <= irq_status_next;
			irq_enable_reg <= irq_enable_next;
			irq_reg        <= irq_next;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rd_data_reg    <= 8'h00;
			summary_reg    <= 1'b0;
			change_irq_reg <= 1'b0;
			wake_reg       <= 1'b0;
		end else begin
			rd_data_reg    <= rd_data_next;
			summary_reg    <= summary_next;
			change_irq_reg <= change_irq_next;
			wake_reg       <= wake_next;
		end
	end

	assign rd_data_o             = rd_data_reg;
	assign change_summary_flag_o = summary_reg;
	assign change_irq_o          = change_irq_reg;
	assign wake_o                = wake_reg;
	assign irq_o                 = irq_reg;
endmodule

// >>> hdl/pin_change_cfg.svh
// Register offsets, field positions and reset values of the pin edge-change block
// Assumes an 8-bit register port and a single 8-pin port
`ifndef PIN_CHANGE_CFG_SVH
`define PIN_CHANGE_CFG_SVH

`define PIN_COUNT         8
`define ADDR_W            8
`define DATA_W            8

`define RISE_EN_OFS       8'h00
`define FALL_EN_OFS       8'h01
`define EDGE_FLAG_OFS     8'h02
`define CONTROL_OFS       8'h03
`define SUMMARY_OFS       8'h04
`define IRQ_STATUS_OFS    8'h05
`define IRQ_CLEAR_OFS     8'h06
`define IRQ_ENABLE_OFS    8'h07

`define CTRL_MASTER_EN_BIT 0
`define CTRL_DISABLE_BIT   1
`define SUMMARY_FLAG_BIT   0

`define PIN_VEC_RESET     8'h00
`define CTRL_RESET        2'h0

`endif

// >>> hdl/pin_change_pkg.sv
// Types shared by the pin edge-change block
// Assumes pin_change_cfg.svh supplies the widths
`include "pin_change_cfg.svh"

package pin_change_pkg;
	typedef logic [`PIN_COUNT-1:0] pin_vec_t;
	typedef logic [`ADDR_W-1:0]    addr_t;
	typedef logic [`DATA_W-1:0]    data_t;
endpackage

// >>> hdl/pin_sync.sv
// Three-flop synchroniser with agreement filter for the port pins
// Assumes pins are asynchronous to mclk_i
`timescale 1ns/1ps
`include "pin_change_cfg.svh"

module pin_sync (
	input  wire logic                      mclk_i,
	input  wire logic                      rst_i,
	input  wire pin_change_pkg::pin_vec_t  pin_i,
	output      pin_change_pkg::pin_vec_t  level_o
);
	pin_change_pkg::pin_vec_t s1_reg;
	pin_change_pkg::pin_vec_t s2_reg;
	pin_change_pkg::pin_vec_t s3_reg;
	pin_change_pkg::pin_vec_t level_reg;

	genvar g;
	generate
		for (g = 0; g < `PIN_COUNT; g++) begin : g_pin
			always_ff @(posedge mclk_i) begin
				if (rst_i) begin
					s1_reg[g]    <= 1'b0;
					s2_reg[g]    <= 1'b0;
					s3_reg[g]    <= 1'b0;
					level_reg[g] <= 1'b0;
				end else begin
					s1_reg[g] <= pin_i[g];
					s2_reg[g] <= s1_reg[g];
					s3_reg[g] <= s2_reg[g];
					if (s2_reg[g] == s3_reg[g]) begin
						level_reg[g] <= s3_reg[g];
					end
				end
			end
		end
	endgenerate

	assign level_o = level_reg;
endmodule

// >>> hdl/edge_detect.sv
// Per-pin rising and falling edge detectors with separate enables
// Assumes a synchronised level input on mclk_i
`timescale 1ns/1ps
`include "pin_change_cfg.svh"

module edge_detect (
	input  wire logic                      mclk_i,
	input  wire logic                      rst_i,
	input  wire pin_change_pkg::pin_vec_t  level_i,
	input  wire pin_change_pkg::pin_vec_t  rise_en_i,
	input  wire pin_change_pkg::pin_vec_t  fall_en_i,
	input  wire logic                      disable_i,
	output      pin_change_pkg::pin_vec_t  edge_o
);
	pin_change_pkg::pin_vec_t prev_reg;
	pin_change_pkg::pin_vec_t rise_w;
	pin_change_pkg::pin_vec_t fall_w;

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			prev_reg <= `PIN_VEC_RESET;
		end else begin
			prev_reg <= level_i;
		end
	end

	assign rise_w = level_i & ~prev_reg & rise_en_i;
	assign fall_w = ~level_i & prev_reg & fall_en_i;
	assign edge_o = disable_i ? `PIN_VEC_RESET : (rise_w | fall_w);
endmodule

// >>> bench/pin_change_asserts.sv
// Port checker for the pin edge-change block
// Assumes binding onto pin_edge_change_interrupt, one clock domain
`timescale 1ns/1ps
module pin_change_asserts (
	input wire logic                     mclk_i,
	input wire logic                     rst_i,
	input wire pin_change_pkg::pin_vec_t porta_pin_i,
	input wire logic                     wr_i,
	input wire logic                     rd_i,
	input wire pin_change_pkg::data_t    rd_data_o,
	input wire logic                     change_summary_flag_o,
	input wire logic                     change_irq_o,
	input wire logic                     wake_o,
	input wire logic                     irq_o
);
	logic [3:0]               quiet_reg;
	logic [3:0]               quiet_next;
	pin_change_pkg::pin_vec_t pin_prev_reg;
	// Cycles since the pins last changed
	assign quiet_next = (porta_pin_i != pin_prev_reg) ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hf};
	always_ff @(posedge mclk_i) begin
		pin_prev_reg <= rst_i ? 8'h00 : porta_pin_i;
		quiet_reg    <= rst_i ? 4'h0 : quiet_next;
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	chk_reset_clear: assert property (disable iff (1'b0)
		$past(rst_i) |-> rd_data_o == 8'h00 && !irq_o && !wake_o && !change_irq_o)
		else $error("outputs not clear after reset");
	chk_read_idle: assert property (!$past(rd_i) |-> rd_data_o == 8'h00)
		else $error("read data outside read answer");
	chk_irq_needs_flag: assert property (change_irq_o |-> change_summary_flag_o)
		else $error("change interrupt without flag");
	chk_wake_flag: assert property (wake_o |-> change_summary_flag_o)
		else $error("wake without flag");
	chk_flag_sticky: assert property (change_summary_flag_o && !wr_i |=> change_summary_flag_o)
		else $error("flag lost without write");
	chk_status_sticky: assert property (irq_o && !wr_i |=> irq_o)
		else $error("interrupt lost without write");
	chk_flag_cause: assert property ($rose(change_summary_flag_o) && !$past(wr_i) |-> quiet_reg <= 4'h6)
		else $error("flag set with no pin change");
	chk_wake_cause: assert property (wake_o |-> quiet_reg <= 4'h6)
		else $error("wake with no pin change");
	cover property (wake_o);
	cover property (irq_o);
	cover property (change_summary_flag_o && !change_irq_o);
endmodule
bind pin_edge_change_interrupt pin_change_asserts i_chk (.mclk_i, .rst_i, .porta_pin_i, .wr_i,
	.rd_i, .rd_data_o, .change_summary_flag_o, .change_irq_o, .wake_o, .irq_o);

// >>> bench/testbench.sv
// Self-checking bench for the pin edge-change block
// Assumes the register map of pin_change_cfg.svh
`timescale 1ns/1ps
`include "pin_change_cfg.svh"
module testbench;
	logic                     mclk_i;
	logic                     rst_i;
	pin_change_pkg::pin_vec_t porta_pin_i;
	pin_change_pkg::addr_t    addr_i;
	pin_change_pkg::data_t    wr_data_i;
	logic                     wr_i;
	logic                     rd_i;
	pin_change_pkg::data_t    rd_data_o;
	logic                     change_summary_flag_o;
	logic                     change_irq_o;
	logic                     wake_o;
	logic                     irq_o;
	int                       mismatches;
	int                       checks_done;
	int                       flg, sts, ien, ctl, rise, fall, e, n;
	logic [31:0]              seed;
	pin_change_pkg::data_t    v;
	pin_edge_change_interrupt i_dut (.mclk_i, .rst_i, .porta_pin_i, .addr_i, .wr_data_i, .wr_i,
		.rd_i, .rd_data_o, .change_summary_flag_o, .change_irq_o, .wake_o, .irq_o);
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input string nm, input logic [7:0] s, input logic [7:0] x);
		checks_done++;
		if (s !== x) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] x);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 v = rd_data_o;
		check(nm, v, x);
	endtask
	task automatic outs();
		check("summary", {7'h0, change_summary_flag_o}, {7'h0, flg != 0});
		check("change irq", {7'h0, change_irq_o}, {7'h0, flg != 0 && ctl[0]});
		check("irq", {7'h0, irq_o}, {7'h0, (sts & ien) != 0});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	initial begin
		#2000000;
		mismatches++;
		tally_and_finish();
	end
	initial begin
		{rst_i, wr_i, rd_i} = 3'h4;
		{porta_pin_i, addr_i, wr_data_i} = 24'h0;
		{mismatches, checks_done, flg, sts, ien, ctl} = '0;
		seed = 32'he7a5ddec;
		repeat (20) @(posedge mclk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 9; a++)
			rc("reset value", a[7:0], 8'h00);
		for (int i = 0; i < 24; i++) begin
			seed = xs(seed);
			{ien, rise, fall, ctl} = {24'h0, seed[31:24], 24'h0, seed[7:0], 24'h0, seed[15:8], i % 4};
			wr(`RISE_EN_OFS, rise[7:0]);
			wr(`FALL_EN_OFS, fall[7:0]);
			wr(`CONTROL_OFS, ctl[7:0]);
			wr(`IRQ_ENABLE_OFS, ien[7:0]);
			rc("rise enable", `RISE_EN_OFS, rise[7:0]);
			rc("fall enable", `FALL_EN_OFS, fall[7:0]);
			@(posedge mclk_i);
			e = (rise & seed[23:16] & ~porta_pin_i) | (fall & ~seed[23:16] & porta_pin_i);
			porta_pin_i <= seed[23:16];
			if (!ctl[1]) begin
				flg |= e;
				sts |= e;
			end
			repeat (8) @(posedge mclk_i);
			#1 outs();
			rc("flags", `EDGE_FLAG_OFS, flg[7:0]);
			rc("summary reg", `SUMMARY_OFS, {7'h0, flg != 0});
			rc("status", `IRQ_STATUS_OFS, sts[7:0]);
			if (i % 2) begin
				rc("flags again", `EDGE_FLAG_OFS, flg[7:0]);
				n = v ^ 8'hff;
				// New edge between complement read and masking write must survive
				@(posedge mclk_i);
				e = (rise & ~porta_pin_i) | (fall & porta_pin_i);
				porta_pin_i <= ~porta_pin_i;
				if (!ctl[1]) begin
					flg |= e;
					sts |= e;
				end
				repeat (8) @(posedge mclk_i);
				rc("flags new edge", `EDGE_FLAG_OFS, flg[7:0]);
				wr(`EDGE_FLAG_OFS, v & n[7:0]);
				flg &= n;
				wr(`IRQ_CLEAR_OFS, 8'hff);
				sts = 0;
			end else begin
				wr(`IRQ_ENABLE_OFS, 8'h00);
				ien = 0;
			end
			repeat (2) @(posedge mclk_i);
			#1 outs();
		end
		wr(`CONTROL_OFS, 8'h01);
		wr(`RISE_EN_OFS, 8'hff);
		wr(`FALL_EN_OFS, 8'hff);
		{ctl, flg, n} = {32'h1, 32'hff, 32'h0};
		sts |= 8'hff;
		@(posedge mclk_i);
		porta_pin_i <= ~porta_pin_i;
		// Clearing write lands in the cycle in which the edge is detected
		repeat (4) @(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= `EDGE_FLAG_OFS;
		wr_data_i <= 8'h00;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		#1 check("wake", {7'h0, wake_o}, 8'h01);
		rc("flags after clear", `EDGE_FLAG_OFS, 8'hff);
		#1 outs();
		tally_and_finish();
	end
endmodule
